/* design/serial_port_defines.svh */
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH
// Register offsets, as byte addresses on the register port.
`define OFS_DATA 8'h00
`define OFS_IER 8'h04
`define OFS_IIR 8'h08
`define OFS_LCR 8'h0C
`define OFS_MCR 8'h10
`define OFS_LSR 8'h14
`define OFS_MSR 8'h18
`define OFS_SCR 8'h1C
`define OFS_ACR 8'h20
`define OFS_FDR 8'h28
`define OFS_TER 8'h30
`define OFS_RSCTL 8'h4C
`define OFS_ADR 8'h50
`define OFS_DLY 8'h54
// Reset values that are not zero.
`define RST_DLL 8'h01
`define RST_FDR 8'h10
`define RST_TER 8'h80
// Field positions.
`define LCR_DIVISOR_SELECT_BIT 7
`define LCR_BRK 6
`define LCR_PEN 3
`define LCR_STOP2 2
`define FCR_EN 0
`define FCR_RXRST 1
`define FCR_TXRST 2
`define TER_EN 7
`define RS_NMM 0
`define RS_RXDIS 1
`define RS_AADEN 2
`define RS_DCTRL 4
`define RS_OINV 5
`define IER_RDA 0
`define IER_THRE 1
`define IER_RLS 2
// FIFO depth and the sixteen sample ticks of one bit.
`define FIFO_DEPTH 5'h10
`define BIT_LAST 4'hF
`define BIT_HALF 4'h7
`endif

/* design/serial_port_pkg.sv */
`default_nettype none
package serial_port_pkg;
	// One register port request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bus_req_t;
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2, TX_PAR = 3'h3, TX_STOP = 3'h4
	} tx_state_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3, RX_STOP = 3'h4
	} rx_state_t;
	// Whole state of the port.
	typedef struct packed {
		logic [7:0] dll, dlm, ier, lcr, mcr, scr, acr, fdr, ter, rsctl, adr, dly;
		logic fcr_en;
		logic [1:0] trig;
		logic [15:0][10:0] rx_mem;
		logic [3:0] rx_wp, rx_rp;
		logic [4:0] rx_cnt;
		logic [15:0][7:0] tx_mem;
		logic [3:0] tx_wp, tx_rp;
		logic [4:0] tx_cnt;
		logic [7:0] pcnt;
		logic [15:0] bcnt;
		logic [3:0] facc;
		logic tick;
		tx_state_t tx_st;
		logic [3:0] tx_sub;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_par;
		rx_state_t rx_st;
		logic [3:0] rx_sub;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_par, rx_on, oe, thre_pend, dcts;
		logic [1:0] rxd_s;
		logic [2:0] cts_s;
		logic [11:0] dcnt;
		logic [31:0] rdata;
		logic txd, rts, dtr;
	} state_t;
endpackage : serial_port_pkg
`default_nettype wire

/* design/serial_port.sv */
`include "serial_port_defines.svh"
`default_nettype none
module serial_port (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic bus_clock_gate_i,
	input wire logic [7:0] baud_clock_divider_i,
	input wire serial_port_pkg::bus_req_t bus_req_i,
	output logic [31:0] rdata_o,
	input wire logic rxd_i,
	input wire logic cts_n_i,
	output logic txd_o,
	output logic rts_n_o,
	output logic dtr_n_o
);
	import serial_port_pkg::*;

	// Registered state and its next value.
	state_t st_reg;
	state_t st_next;

	// Gated strobes and decoded conditions.
	logic wr;
	logic rd;
	logic divisor_select_bit;
	logic [2:0] last_bit;
	logic [7:0] mask;
	logic [15:0] dv;
	logic [3:0] mulv;
	logic [10:0] rx_top;
	logic rx_avail;
	logic rx_full;
	logic tx_avail;
	logic tx_full;
	logic thre;
	logic temt;
	logic [7:0] lsr;
	logic [7:0] iir;
	logic rda;
	logic dir;

	// FIFO actions decided inside the next-state process.
	logic rx_push;
	logic rx_pop;
	logic tx_push;
	logic tx_pop;
	logic rx_rst;
	logic tx_rst;
	logic keep;
	logic perr;
	logic [10:0] rx_word;
	logic [4:0] fsum;

	// Receive trigger level as a byte count.
	function automatic logic [4:0] trig_lvl(input logic [1:0] sel);
		case (sel)
			2'h0: trig_lvl = 5'h01;
			2'h1: trig_lvl = 5'h04;
			2'h2: trig_lvl = 5'h08;
			default: trig_lvl = 5'h0E;
		endcase
	endfunction : trig_lvl

	// Parity of the masked data for the configured parity type.
	function automatic logic par_of(input logic [7:0] d, input logic [1:0] kind);
		case (kind)
			2'h0: par_of = ~^d;
			2'h1: par_of = ^d;
			2'h2: par_of = 1'b1;
			default: par_of = 1'b0;
		endcase
	endfunction : par_of

	// The bus clock gate stops every register access while it is clear.
	assign wr = bus_req_i.wr & bus_clock_gate_i;
	assign rd = bus_req_i.rd & bus_clock_gate_i;
	assign divisor_select_bit = st_reg.lcr[`LCR_DIVISOR_SELECT_BIT];
	// Last data bit index, 4 to 7 for five to eight bits.
	assign last_bit = 3'h4 + {1'b0, st_reg.lcr[1:0]};
	assign mask = 8'hFF >> (2'h3 - st_reg.lcr[1:0]);
	// A zero divisor would stall the generator, so it counts as one.
	assign dv = ({st_reg.dlm, st_reg.dll} == 16'h0000) ? 16'h0001 : {st_reg.dlm, st_reg.dll};
	assign mulv = (st_reg.fdr[7:4] == 4'h0) ? 4'h1 : st_reg.fdr[7:4];
	assign rx_top = st_reg.rx_mem[st_reg.rx_rp];
	assign rx_avail = st_reg.rx_cnt != 5'h00;
	assign tx_avail = st_reg.tx_cnt != 5'h00;
	// With the FIFOs off each side holds a single character.
	assign rx_full = st_reg.fcr_en ? (st_reg.rx_cnt == `FIFO_DEPTH) : rx_avail;
	assign tx_full = st_reg.fcr_en ? (st_reg.tx_cnt == `FIFO_DEPTH) : tx_avail;
	assign thre = !tx_avail;
	assign temt = thre && (st_reg.tx_st == TX_IDLE);
	// Error flags belong to the character at the head of the FIFO.
	assign lsr = {rx_avail & (|rx_top[10:8]), temt, thre,
		rx_avail ? rx_top[10:8] : 3'h0, st_reg.oe, rx_avail};
	assign rda = st_reg.rx_cnt >= (st_reg.fcr_en ? trig_lvl(st_reg.trig) : 5'h01);

	// Highest pending source: line status, then data, then empty holding.
	always_comb begin
		if (st_reg.ier[`IER_RLS] && (st_reg.oe || (|lsr[4:2]))) begin
			iir = 8'h06;
		end else if (st_reg.ier[`IER_RDA] && rda) begin
			iir = 8'h04;
		end else if (st_reg.ier[`IER_THRE] && st_reg.thre_pend) begin
			iir = 8'h02;
		end else begin
			iir = 8'h01;
		end
		iir[7:6] = {st_reg.fcr_en, st_reg.fcr_en};
	end

	// The direction output stays active while sending and for the delay after.
	assign dir = (st_reg.tx_st != TX_IDLE) || (st_reg.dcnt != 12'h000);

	// One process builds the whole next state.
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		st_next.rdata = 32'h0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_rst = 1'b0;
		tx_rst = 1'b0;
		keep = 1'b0;
		perr = 1'b0;
		rx_word = 11'h000;
		fsum = 5'h00;

		// Pins pass two flip-flops; the third cts stage feeds the change flag.
		st_next.rxd_s = {st_reg.rxd_s[0], rxd_i};
		st_next.cts_s = {st_reg.cts_s[1:0], cts_n_i};

		// Peripheral clock enable; a divider of zero stops it to save power.
		if (baud_clock_divider_i == 8'h00) begin
			st_next.pcnt = 8'h00;
		end else if (st_reg.pcnt >= baud_clock_divider_i - 8'h01) begin
			st_next.pcnt = 8'h00;
			// Divisor counter gives sixteen ticks per bit.
			if (st_reg.bcnt == 16'h0000) begin
				st_next.tick = 1'b1;
				fsum = {1'b0, st_reg.facc} + {1'b0, st_reg.fdr[3:0]};
				// Fractional carry stretches one period by one peripheral clock.
				if ((st_reg.fdr[3:0] != 4'h0) && (fsum >= {1'b0, mulv})) begin
					st_next.facc = 4'(fsum - {1'b0, mulv});
					st_next.bcnt = dv;
				end else begin
					st_next.facc = fsum[3:0];
					st_next.bcnt = dv - 16'h0001;
				end
			end else begin
				st_next.bcnt = st_reg.bcnt - 16'h0001;
			end
		end else begin
			st_next.pcnt = st_reg.pcnt + 8'h01;
		end

		// Register reads, with their side effects.
		if (rd) begin
			case (bus_req_i.addr)
				`OFS_DATA: begin
					if (divisor_select_bit) begin
						st_next.rdata = {24'h0, st_reg.dll};
					end else begin
						// Reading the head consumes it.
						st_next.rdata = {24'h0, rx_top[7:0]};
						rx_pop = rx_avail;
					end
				end
				`OFS_IER: st_next.rdata = {24'h0, divisor_select_bit ? st_reg.dlm : st_reg.ier};
				`OFS_IIR: begin
					st_next.rdata = {24'h0, iir};
					// Reading the identity clears an empty-holding report.
					if (iir[3:0] == 4'h2) begin
						st_next.thre_pend = 1'b0;
					end
				end
				`OFS_LCR: st_next.rdata = {24'h0, st_reg.lcr};
				`OFS_MCR: st_next.rdata = {24'h0, st_reg.mcr};
				`OFS_LSR: begin
					st_next.rdata = {24'h0, lsr};
					st_next.oe = 1'b0;
				end
				`OFS_MSR: begin
					st_next.rdata = {24'h0, 3'h0, ~st_reg.cts_s[2], 3'h0, st_reg.dcts};
					st_next.dcts = 1'b0;
				end
				`OFS_SCR: st_next.rdata = {24'h0, st_reg.scr};
				`OFS_ACR: st_next.rdata = {24'h0, st_reg.acr};
				`OFS_FDR: st_next.rdata = {24'h0, st_reg.fdr};
				`OFS_TER: st_next.rdata = {24'h0, st_reg.ter};
				`OFS_RSCTL: st_next.rdata = {24'h0, st_reg.rsctl};
				`OFS_ADR: st_next.rdata = {24'h0, st_reg.adr};
				`OFS_DLY: st_next.rdata = {24'h0, st_reg.dly};
				default: st_next.rdata = 32'h0;
			endcase
		end

		// Register writes; reserved offsets are dropped.
		if (wr) begin
			case (bus_req_i.addr)
				`OFS_DATA: begin
					if (divisor_select_bit) begin
						st_next.dll = bus_req_i.wdata[7:0];
					end else begin
						// A write to a full FIFO is lost.
						tx_push = !tx_full;
						st_next.thre_pend = 1'b0;
					end
				end
				`OFS_IER: begin
					if (divisor_select_bit) begin
						st_next.dlm = bus_req_i.wdata[7:0];
					end else begin
						st_next.ier = {5'h00, bus_req_i.wdata[2:0]};
					end
				end
				`OFS_IIR: begin
					st_next.fcr_en = bus_req_i.wdata[`FCR_EN];
					st_next.trig = bus_req_i.wdata[7:6];
					// Toggling the enable also flushes, so no stale data survives.
					rx_rst = bus_req_i.wdata[`FCR_RXRST] || (bus_req_i.wdata[`FCR_EN] != st_reg.fcr_en);
					tx_rst = bus_req_i.wdata[`FCR_TXRST] || (bus_req_i.wdata[`FCR_EN] != st_reg.fcr_en);
				end
				`OFS_LCR: st_next.lcr = bus_req_i.wdata[7:0];
				`OFS_MCR: st_next.mcr = bus_req_i.wdata[7:0];
				`OFS_SCR: st_next.scr = bus_req_i.wdata[7:0];
				`OFS_ACR: st_next.acr = bus_req_i.wdata[7:0];
				`OFS_FDR: st_next.fdr = bus_req_i.wdata[7:0];
				`OFS_TER: st_next.ter = {bus_req_i.wdata[7], 7'h00};
				`OFS_RSCTL: st_next.rsctl = {2'h0, bus_req_i.wdata[5:0]};
				`OFS_ADR: st_next.adr = bus_req_i.wdata[7:0];
				`OFS_DLY: st_next.dly = bus_req_i.wdata[7:0];
				default: begin
				end
			endcase
		end

		// Transmitter; a new character starts only while enabled.
		case (st_reg.tx_st)
			TX_IDLE: begin
				if (st_reg.tick && tx_avail && st_reg.ter[`TER_EN]) begin
					tx_pop = 1'b1;
					st_next.tx_sh = st_reg.tx_mem[st_reg.tx_rp] & mask;
					st_next.tx_par = par_of(st_reg.tx_mem[st_reg.tx_rp] & mask, st_reg.lcr[5:4]);
					st_next.tx_st = TX_START;
					st_next.tx_sub = 4'h0;
					st_next.tx_bit = 3'h0;
				end
			end
			default: begin
				if (st_reg.tick) begin
					st_next.tx_sub = st_reg.tx_sub + 4'h1;
					if (st_reg.tx_sub == `BIT_LAST) begin
						case (st_reg.tx_st)
							TX_START: st_next.tx_st = TX_DATA;
							TX_DATA: begin
								// Shift right so bit 0 leaves first.
								st_next.tx_sh = {1'b0, st_reg.tx_sh[7:1]};
								st_next.tx_bit = st_reg.tx_bit + 3'h1;
								if (st_reg.tx_bit == last_bit) begin
									st_next.tx_bit = 3'h0;
									st_next.tx_st = st_reg.lcr[`LCR_PEN] ? TX_PAR : TX_STOP;
								end
							end
							TX_PAR: st_next.tx_st = TX_STOP;
							TX_STOP: begin
								// Second stop bit when selected.
								if ((st_reg.tx_bit == 3'h0) && st_reg.lcr[`LCR_STOP2]) begin
									st_next.tx_bit = 3'h1;
								end else begin
									st_next.tx_st = TX_IDLE;
								end
							end
							default: st_next.tx_st = TX_IDLE;
						endcase
					end
				end
			end
		endcase
		// The last character leaving raises the empty-holding report.
		if (tx_pop && (st_reg.tx_cnt == 5'h01) && !tx_push) begin
			st_next.thre_pend = 1'b1;
		end

		// Line level follows the next state; break wins over everything.
		case (st_next.tx_st)
			TX_START: st_next.txd = 1'b0;
			TX_DATA: st_next.txd = st_next.tx_sh[0];
			TX_PAR: st_next.txd = st_next.tx_par;
			default: st_next.txd = 1'b1;
		endcase
		if (st_reg.lcr[`LCR_BRK]) begin
			st_next.txd = 1'b0;
		end

		// Receiver; sampling is at mid-bit, counted from the start edge.
		case (st_reg.rx_st)
			RX_IDLE: begin
				if (st_reg.tick && !st_reg.rxd_s[1] && !st_reg.rsctl[`RS_RXDIS]) begin
					st_next.rx_st = RX_START;
					st_next.rx_sub = 4'h0;
					st_next.rx_sh = 8'h00;
					st_next.rx_bit = 3'h0;
				end
			end
			RX_START: begin
				if (st_reg.tick) begin
					st_next.rx_sub = st_reg.rx_sub + 4'h1;
					if (st_reg.rx_sub == `BIT_HALF) begin
						// A glitch shorter than half a bit is ignored.
						st_next.rx_st = st_reg.rxd_s[1] ? RX_IDLE : RX_DATA;
						st_next.rx_sub = 4'h0;
					end
				end
			end
			default: begin
				if (st_reg.tick) begin
					st_next.rx_sub = st_reg.rx_sub + 4'h1;
					if (st_reg.rx_sub == `BIT_LAST) begin
						case (st_reg.rx_st)
							RX_DATA: begin
								// First bit lands in bit 0; upper bits stay zero.
								st_next.rx_sh[st_reg.rx_bit] = st_reg.rxd_s[1];
								st_next.rx_bit = st_reg.rx_bit + 3'h1;
								if (st_reg.rx_bit == last_bit) begin
									st_next.rx_st = st_reg.lcr[`LCR_PEN] ? RX_PAR : RX_STOP;
								end
							end
							RX_PAR: begin
								st_next.rx_par = st_reg.rxd_s[1];
								st_next.rx_st = RX_STOP;
							end
							default: begin
								st_next.rx_st = RX_IDLE;
								// In nine-bit mode the parity bit marks an address.
								perr = st_reg.lcr[`LCR_PEN] && !st_reg.rsctl[`RS_NMM] &&
									(st_reg.rx_par != par_of(st_reg.rx_sh, st_reg.lcr[5:4]));
								rx_word = {!st_reg.rxd_s[1] && (st_reg.rx_sh == 8'h00),
									!st_reg.rxd_s[1], perr, st_reg.rx_sh};
								if (st_reg.rsctl[`RS_NMM] && st_reg.rx_par) begin
									// Address match opens or closes the receiver.
									st_next.rx_on = st_reg.rx_sh == st_reg.adr;
									keep = !st_reg.rsctl[`RS_AADEN];
								end else begin
									keep = !st_reg.rsctl[`RS_NMM] || !st_reg.rsctl[`RS_AADEN] || st_reg.rx_on;
								end
								if (keep && rx_full && !rx_pop) begin
									st_next.oe = 1'b1;
								end else if (keep) begin
									rx_push = 1'b1;
								end
							end
						endcase
					end
				end
			end
		endcase

		// FIFO storage; the flush from the control write wins.
		if (rx_push) begin
			st_next.rx_mem[st_reg.rx_wp] = rx_word;
			st_next.rx_wp = st_reg.rx_wp + 4'h1;
		end
		if (rx_pop) begin
			st_next.rx_rp = st_reg.rx_rp + 4'h1;
		end
		st_next.rx_cnt = st_reg.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
		if (tx_push) begin
			st_next.tx_mem[st_reg.tx_wp] = bus_req_i.wdata[7:0];
			st_next.tx_wp = st_reg.tx_wp + 4'h1;
		end
		if (tx_pop) begin
			st_next.tx_rp = st_reg.tx_rp + 4'h1;
		end
		st_next.tx_cnt = st_reg.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
		if (rx_rst) begin
			st_next.rx_wp = 4'h0;
			st_next.rx_rp = 4'h0;
			st_next.rx_cnt = 5'h00;
		end
		if (tx_rst) begin
			st_next.tx_wp = 4'h0;
			st_next.tx_rp = 4'h0;
			st_next.tx_cnt = 5'h00;
		end

		// A change on clear-to-send sets the delta flag; set wins over read.
		if (st_reg.cts_s[1] != st_reg.cts_s[2]) begin
			st_next.dcts = 1'b1;
		end

		// Release delay counts whole bit times after the last stop bit.
		if (st_reg.tx_st != TX_IDLE) begin
			st_next.dcnt = {st_reg.dly, 4'h0};
		end else if (st_reg.tick && (st_reg.dcnt != 12'h000)) begin
			st_next.dcnt = st_reg.dcnt - 12'h001;
		end

		// Request-to-send carries the direction when direction control is on.
		if (st_reg.rsctl[`RS_DCTRL]) begin
			st_next.rts = st_reg.rsctl[`RS_OINV] ? dir : !dir;
		end else begin
			st_next.rts = !st_reg.mcr[1];
		end
		st_next.dtr = !st_reg.mcr[0];
	end

	// State register; idle line and inactive modem outputs at reset.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
			st_reg.dll <= `RST_DLL;
			st_reg.fdr <= `RST_FDR;
			st_reg.ter <= `RST_TER;
			st_reg.rxd_s <= 2'h3;
			st_reg.cts_s <= 3'h7;
			st_reg.txd <= 1'b1;
			st_reg.rts <= 1'b1;
			st_reg.dtr <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state register.
	assign rdata_o = st_reg.rdata;
	assign txd_o = st_reg.txd;
	assign rts_n_o = st_reg.rts;
	assign dtr_n_o = st_reg.dtr;

	// Checks on the register and line behaviour.
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	fifo_depth_a: assert property (st_reg.rx_cnt <= `FIFO_DEPTH && st_reg.tx_cnt <= `FIFO_DEPTH)
		else $error("FIFO count above sixteen.");
	trig_level_a: assert property (iir[3:0] == 4'h4 |-> rda && st_reg.rx_cnt != 5'h00)
		else $error("Data report below trigger level.");
	divisor_select_bit_read_a: assert property (rd && bus_req_i.addr == `OFS_DATA && divisor_select_bit |=>
		rdata_o == {24'h0, $past(st_reg.dll)})
		else $error("Divisor low byte not read back.");
	thr_push_a: assert property (wr && bus_req_i.addr == `OFS_DATA && !divisor_select_bit && !tx_full && !tx_pop |=>
		st_reg.tx_cnt == 5'($past(st_reg.tx_cnt) + 5'h01))
		else $error("Transmit write not queued.");
	break_line_a: assert property (st_reg.lcr[`LCR_BRK] |=> !txd_o)
		else $error("Break did not hold line low.");
	lsr_empty_a: assert property (rd && bus_req_i.addr == `OFS_LSR |=>
		rdata_o[5] == ($past(st_reg.tx_cnt) == 5'h00))
		else $error("Holding empty flag wrong.");
	scratch_rw_a: assert property (wr && bus_req_i.addr == `OFS_SCR ##1 rd && bus_req_i.addr == `OFS_SCR |=>
		rdata_o[7:0] == $past(bus_req_i.wdata[7:0], 2))
		else $error("Scratch value lost.");
	ter_hold_a: assert property (!st_reg.ter[`TER_EN] && st_reg.tx_st == TX_IDLE |=>
		st_reg.tx_st == TX_IDLE)
		else $error("Transmitter started while disabled.");
	rts_dir_a: assert property (st_reg.rsctl[`RS_DCTRL] && st_reg.tx_st != TX_IDLE |=>
		rts_n_o == $past(st_reg.rsctl[`RS_OINV]))
		else $error("Direction output not active while sending.");
	gate_off_a: assert property (!bus_clock_gate_i |=> rdata_o == 32'h0)
		else $error("Register read while bus clock gated.");
	pclk_stop_a: assert property (baud_clock_divider_i == 8'h00 |=> !st_reg.tick)
		else $error("Baud tick with peripheral clock off.");
endmodule : serial_port
`default_nettype wire

/* testbench/far_serial.sv */
`default_nettype none
// Remote serial device: sends frames on the receive line and captures frames from the transmit line.
module far_serial (
	input wire logic clk_i,
	input wire logic txd_i,
	output var logic rxd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BitCyc = 32; // Sixteen ticks of two core cycles each.
	int n_rx = 0; // Number of frames captured so far.
	logic [7:0] last_rx = 8'h00; // Last captured character.
	logic last_stop = 1'b1; // Level seen in the middle of the last stop bit.
	initial rxd_o = 1'b1; // The line idles high between frames.
	// Sends one frame: low start bit, nb bits LSB first, then one high stop bit; bit 8 is the parity slot.
	task automatic send(input logic [8:0] b, input int nb);
		rxd_o <= 1'b0;
		repeat (BitCyc) @(posedge clk_i);
		for (int i = 0; i < nb; i++) begin
			rxd_o <= b[i];
			repeat (BitCyc) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
		repeat (BitCyc) @(posedge clk_i);
	endtask : send
	// Sampling in mid-bit keeps the capture clear of the edges where the line changes.
	initial begin
		forever begin
			@(negedge txd_i);
			repeat (BitCyc / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (BitCyc) @(posedge clk_i);
				last_rx = {txd_i, last_rx[7:1]};
			end
			repeat (BitCyc) @(posedge clk_i);
			last_stop = txd_i;
			n_rx++;
		end
	end
endmodule : far_serial
`default_nettype wire

/* testbench/tb.sv */
`default_nettype none
module tb;
	import serial_port_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, gate, cts_n, txd, rts_n, dtr_n, rxd;
	logic [7:0] cdiv;
	bus_req_t req;
	logic [31:0] rdata;
	int num_errors = 0;
	int n_checks = 0;
	// Offsets and reset values checked right after reset.
	logic [7:0] ra [12] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h28, 8'h30, 8'h4C, 8'h50, 8'h54};
	logic [7:0] re [12] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h10, 8'h80, 8'h00, 8'h00, 8'h00};
	serial_port uut (.core_clk_i(clk), .sys_rst_i(rst), .bus_clock_gate_i(gate), .baud_clock_divider_i(cdiv),
		.bus_req_i(req), .rdata_o(rdata), .rxd_i(rxd), .cts_n_i(cts_n), .txd_o(txd), .rts_n_o(rts_n), .dtr_n_o(dtr_n));
	far_serial far (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Counts results and closes the run.
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// One-cycle write strobe; the strobe drops at the next edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: {24'h000000, d}};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so they are taken just after that edge.
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rdchk
	// Waits for the remote device to have captured n frames, giving up after a bound.
	task automatic wait_rx(input int n);
		int k;
		k = 0;
		while (far.n_rx < n) begin
			@(posedge clk);
			k++;
			if (k > 3000) begin
				num_errors++;
				report_and_stop();
			end
		end
	endtask : wait_rx
	initial begin
		rst = 1'b1;
		gate = 1'b1;
		cts_n = 1'b1;
		// Two core cycles per peripheral tick, so one sample tick every two cycles as the remote device expects.
		cdiv = 8'h02;
		req = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		chk({31'h0, rts_n}, 32'h1);
		for (int i = 0; i < 12; i++) rdchk(ra[i], {24'h0, re[i]});
		wr(8'h24, 8'hFF);
		rdchk(8'h24, 32'h0);
		wr(8'h1C, 8'h5A);
		wr(8'h50, 8'hA5);
		rdchk(8'h1C, 32'h5A);
		rdchk(8'h50, 32'hA5);
		wr(8'h10, 8'h01);
		// The pin follows the register one cycle after the write lands.
		repeat (2) @(posedge clk);
		chk({31'h0, dtr_n}, 32'h0);
		// With the gate low, accesses must leave no trace.
		@(posedge clk) gate <= 1'b0;
		wr(8'h1C, 8'hFF);
		rdchk(8'h1C, 32'h0);
		@(posedge clk) gate <= 1'b1;
		rdchk(8'h1C, 32'h5A);
		wr(8'h0C, 8'h83);
		rdchk(8'h00, 32'h01);
		rdchk(8'h04, 32'h00);
		// A zero divisor must run at the same rate as one, which the remote device relies on.
		wr(8'h00, 8'h00);
		rdchk(8'h00, 32'h00);
		rdchk(8'h0C, 32'h83);
		wr(8'h0C, 8'h03);
		wr(8'h4C, 8'h10);
		wr(8'h00, 8'hA5);
		repeat (120) @(posedge clk);
		chk({31'h0, rts_n}, 32'h0);
		rdchk(8'h14, 32'h20);
		wait_rx(1);
		chk({24'h0, far.last_rx}, 32'hA5);
		chk({31'h0, far.last_stop}, 32'h1);
		repeat (40) @(posedge clk);
		chk({31'h0, rts_n}, 32'h1);
		// Transmitter paused: a queued character must wait.
		wr(8'h30, 8'h00);
		wr(8'h00, 8'h3C);
		repeat (400) @(posedge clk);
		chk(far.n_rx, 1);
		wr(8'h30, 8'h80);
		wait_rx(2);
		chk({24'h0, far.last_rx}, 32'h3C);
		far.send(8'h96, 8);
		repeat (8) @(posedge clk);
		rdchk(8'h14, 32'h61);
		rdchk(8'h00, 32'h96);
		wr(8'h0C, 8'h02);
		far.send(8'hFF, 7);
		repeat (8) @(posedge clk);
		rdchk(8'h00, 32'h7F);
		wr(8'h0C, 8'h03);
		// FIFO on, trigger at fourteen, then fill past sixteen to force an overrun.
		wr(8'h08, 8'hC1);
		wr(8'h04, 8'h01);
		for (int i = 0; i < 13; i++) far.send(8'h10 + 8'(i), 8);
		repeat (8) @(posedge clk);
		rdchk(8'h08, 32'hC1);
		far.send(8'h1D, 8);
		repeat (8) @(posedge clk);
		rdchk(8'h08, 32'hC4);
		for (int i = 14; i < 17; i++) far.send(8'h10 + 8'(i), 8);
		repeat (8) @(posedge clk);
		rdchk(8'h14, 32'h63);
		for (int i = 0; i < 16; i++) rdchk(8'h00, 32'h10 + i);
		rdchk(8'h14, 32'h60);
		// Nine-bit mode with auto address: only data after a matching address is kept.
		wr(8'h0C, 8'h0B);
		wr(8'h4C, 8'h05);
		far.send(9'h1A5, 9);
		far.send(9'h033, 9);
		far.send(9'h1A6, 9);
		far.send(9'h044, 9);
		repeat (8) @(posedge clk);
		rdchk(8'h14, 32'h61);
		rdchk(8'h00, 32'h33);
		rdchk(8'h14, 32'h60);
		wr(8'h0C, 8'h03);
		// Peripheral clock off: a queued character must not leave until it runs again.
		@(posedge clk) cdiv <= 8'h00;
		wr(8'h00, 8'h5C);
		repeat (400) @(posedge clk);
		chk(far.n_rx, 2);
		@(posedge clk) cdiv <= 8'h02;
		wait_rx(3);
		chk({24'h0, far.last_rx}, 32'h5C);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
